// ==== board_info_pkg.sv ====
package board_info_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [11:0] idx_board_command          = 12'h000;
    localparam logic [11:0] idx_driver_library_version = 12'h4b0;
    localparam logic [11:0] idx_kernel_driver_version  = 12'h4ba;
    localparam logic [11:0] idx_driver_kind            = 12'h4c4;
    localparam logic [11:0] idx_interrupt_line_used    = 12'h8fc;

    // ----------------------------------------------------------------
    // command codes and field limits
    // ----------------------------------------------------------------
    localparam logic [31:0] enter_low_power_cmd  = 32'h0000001e;
    localparam logic [31:0] full_board_reset_cmd = 32'h00000000;
    localparam logic [31:0] command_reset_value  = 32'h00000000;
    localparam logic [2:0]  driver_kind_max      = 3'h7;
    localparam logic [31:0] unmapped_read_value  = 32'h00000000;

    typedef enum logic [0:0] {
        mode_normal     = 1'b0,
        mode_power_down = 1'b1
    } power_mode_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] index;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        power_mode_e mode;
        logic [31:0] command;
        logic        mem_valid;
        logic        cfg_reset;
        logic [31:0] rdata;
    } state_s;

endpackage

// ==== board_info_and_power_command.sv ====
// What this block does
// - read-only register shows the interrupt line assigned to the board.
// - read-only register shows driver kind code, range zero to seven.
// - read-only register returns the user-level driver library version.
// - read-only register returns the kernel driver version in use.
// - command register is readable and writable, selecting board-wide actions.
// - writing thirty enters power-down mode with reduced consumption.
// - power-down is left on reset command or start of acquisition.
// - power-down entry or reset marks all on-board memory contents invalid.
// - writing zero performs combined software and hardware board reset.
// - reset command restores every configuration setting to default.
`timescale 1ns/1ns
module board_info_and_power_command
    import board_info_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // register port
    input  wire reg_req_s    req,
    output logic [31:0]      rdata,
    // board information inputs, static from the driver side
    input  wire logic [7:0]  irq_line,
    input  wire logic [2:0]  drv_kind,
    input  wire logic [31:0] lib_version,
    input  wire logic [31:0] kernel_version,
    // acquisition and board control
    input  wire logic        acq_start,
    input  wire logic        mem_written,
    output logic             power_down,
    output logic             mem_valid,
    output logic             cfg_reset
);


    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int reg_count = 5;

    localparam int slot_board_command          = 0;
    localparam int slot_driver_library_version = 1;
    localparam int slot_kernel_driver_version  = 2;
    localparam int slot_driver_kind            = 3;
    localparam int slot_interrupt_line_used    = 4;

    // table order must follow the slot numbers above
    localparam logic [11:0] reg_index_table [reg_count] = '{
        idx_board_command,
        idx_driver_library_version,
        idx_kernel_driver_version,
        idx_driver_kind,
        idx_interrupt_line_used
    };

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    state_s s_q;
    state_s s_d;

    // ----------------------------------------------------------------
    // decode signals
    // ----------------------------------------------------------------
    logic                 command_write;
    logic                 power_down_request;
    logic                 board_reset_request;
    logic                 command_ignored;
    logic                 power_down_now;
    logic                 wake_request;

    // ----------------------------------------------------------------
    // read path signals
    // ----------------------------------------------------------------
    logic [reg_count-1:0] read_hit;
    logic [31:0]          read_value [reg_count];
    logic [31:0]          read_word;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // only the command register is writable; writes elsewhere fall away
    assign command_write = req.wr && (req.index == idx_board_command);

    assign power_down_request = command_write
                              && (req.wdata == enter_low_power_cmd);

    assign board_reset_request = command_write
                               && (req.wdata == full_board_reset_cmd);

    assign command_ignored = command_write
                           && !power_down_request
                           && !board_reset_request;

    assign power_down_now = (s_q.mode == mode_power_down);

    assign wake_request = acq_start && power_down_now;

    // ----------------------------------------------------------------
    // read values, one per slot
    // ----------------------------------------------------------------
    assign read_value[slot_board_command] = s_q.command;

    assign read_value[slot_driver_library_version] = lib_version;

    assign read_value[slot_kernel_driver_version] = kernel_version;

    // the code is clipped to its documented range of zero to seven
    assign read_value[slot_driver_kind] = {29'h0, drv_kind & driver_kind_max};

    assign read_value[slot_interrupt_line_used] = {24'h0, irq_line};

    // ----------------------------------------------------------------
    // address match, one comparator per register
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < reg_count; g++) begin : g_read_hit
            assign read_hit[g] = req.rd && (req.index == reg_index_table[g]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // read select
    // ----------------------------------------------------------------
    // indices are distinct, so at most one hit is ever set
    always_comb begin
        read_word = unmapped_read_value;
        for (int i = 0; i < reg_count; i++) begin
            if (read_hit[i]) begin
                read_word = read_value[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // pulse lasts one cycle unless a new reset command arrives
        s_d.cfg_reset = 1'b0;

        // read data stands for one cycle only, then falls back to idle
        s_d.rdata = read_word;

        // fill first, so a power-down or reset command in the same cycle still clears validity
        if (mem_written) begin
            s_d.mem_valid = 1'b1;
        end

        // a start leaves power-down; the memory stays invalid until refilled
        if (wake_request) begin
            s_d.mode = mode_normal;
        end

        if (power_down_request) begin
            s_d.command   = req.wdata;
            s_d.mode      = mode_power_down;
            s_d.mem_valid = 1'b0;
        end

        if (board_reset_request) begin
            s_d.command   = req.wdata;
            s_d.mode      = mode_normal;
            s_d.mem_valid = 1'b0;
            s_d.cfg_reset = 1'b1;
        end

        if (command_ignored) begin
            s_d.command = s_q.command;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q.mode      <= mode_normal;
            s_q.command   <= command_reset_value;
            s_q.mem_valid <= 1'b0;
            s_q.cfg_reset <= 1'b1;
            s_q.rdata     <= unmapped_read_value;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata = s_q.rdata;

    // low-power gating elsewhere on the board keys off this level
    assign power_down = (s_q.mode == mode_power_down);

    // readout and replay logic must refuse data while this is low
    assign mem_valid = s_q.mem_valid;

    // pulse lets every configuration register on the board return to default
    assign cfg_reset = s_q.cfg_reset;

endmodule

// ==== board_info_monitor.sv ====
`timescale 1ns/1ns
module board_info_monitor import board_info_pkg::*; (
    input wire logic        mclk, srst, power_down, mem_valid, cfg_reset, acq_start,
    input wire logic [31:0] rdata,
    input wire reg_req_s    req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire logic cw = req.wr && req.index == idx_board_command;
    sequence s_pd_cmd; cw && req.wdata == enter_low_power_cmd; endsequence
    sequence s_rs_cmd; cw && req.wdata == full_board_reset_cmd; endsequence
    sequence s_kind_rd; req.rd && req.index == idx_driver_kind; endsequence
    property p_pd; s_pd_cmd |=> power_down && !mem_valid; endproperty
    a_pd: assert property (p_pd) else $error("no power-down");
    property p_rs; s_rs_cmd |=> cfg_reset && !power_down && !mem_valid; endproperty
    a_rs: assert property (p_rs) else $error("no reset");
    property p_kd; s_kind_rd |=> rdata[31:3] == 29'h0; endproperty
    a_kd: assert property (p_kd) else $error("driver kind out of range");
    property p_wk; power_down && acq_start && !req.wr |=> !power_down; endproperty
    a_wk: assert property (p_wk) else $error("no wake");
    property p_ig;
        cw && req.wdata != full_board_reset_cmd && req.wdata != enter_low_power_cmd && !acq_start
        |=> $stable(power_down);
    endproperty
    a_ig: assert property (p_ig) else $error("command acted on");
    property p_cf; cfg_reset |=> !cfg_reset || $past(cw && req.wdata == full_board_reset_cmd); endproperty
    a_cf: assert property (p_cf) else $error("long reset pulse");
endmodule
bind board_info_and_power_command board_info_monitor mon (.*);

// ==== board_host_model.sv ====
`timescale 1ns/1ns
module board_host_model import board_info_pkg::*; (
    input wire logic        mclk,
    input wire logic [31:0] rdata,
    output reg_req_s        req
);
    initial req = '0;
    // one access per call, so the bus idles a cycle between calls
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        @(posedge mclk) req <= '{1'b1, 1'b0, i, d};
        @(posedge mclk) req <= '0;
    endtask
    task automatic rd(input logic [11:0] i, output logic [31:0] d);
        @(posedge mclk) req <= '{1'b0, 1'b1, i, 32'h0};
        @(posedge mclk) req <= '0;
        #1 d = rdata;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import board_info_pkg::*;
    logic        mclk = 0, srst = 1, acq_start = 0, mem_written = 0, power_down, mem_valid, cfg_reset;
    logic [7:0]  irq_line = 8'h0b;
    logic [2:0]  drv_kind = 3'h7;
    logic [31:0] lib_version = 32'h00010203, kernel_version = 32'h00040506, rdata, v;
    reg_req_s    req;
    int          failures = 0, check_count = 0;
    board_host_model host (.mclk(mclk), .rdata(rdata), .req(req));
    board_info_and_power_command DUT (.*);
    initial forever #5 mclk = ~mclk;
    task chk(input string n, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task fill;
        @(posedge mclk) mem_written <= 1;
        @(posedge mclk) mem_written <= 0;
        #1 chk("mem_valid fill", 32'h1, mem_valid);
    endtask
    task info;
        host.rd(idx_interrupt_line_used, v); chk("interrupt_line_used", 32'h0000000b, v);
        @(posedge mclk) #1 chk("rdata idle", unmapped_read_value, rdata);
        host.rd(idx_driver_library_version, v); chk("driver_library_version", 32'h00010203, v);
        host.rd(idx_kernel_driver_version, v); chk("kernel_driver_version", 32'h00040506, v);
        host.wr(idx_driver_kind, 32'h0); host.rd(idx_driver_kind, v); chk("driver_kind", 32'h7, v);
        host.rd(12'h001, v); chk("unmapped", unmapped_read_value, v);
    endtask
    task power;
        fill;
        host.wr(idx_board_command, enter_low_power_cmd); #1 chk("pd mv", 32'h2, {power_down, mem_valid});
        host.rd(idx_board_command, v); chk("board_command", enter_low_power_cmd, v);
        host.wr(idx_board_command, 32'h5); #1 chk("power_down", 32'h1, power_down);
        host.rd(idx_board_command, v); chk("board_command", enter_low_power_cmd, v);
        @(posedge mclk) acq_start <= 1;
        @(posedge mclk) acq_start <= 0;
        #1 chk("power_down wake", 32'h0, power_down);
    endtask
    task cmd_reset;
        host.wr(idx_board_command, enter_low_power_cmd);
        fill;
        host.wr(idx_board_command, full_board_reset_cmd); #1 chk("pd mv cfg", 32'h1, {power_down, mem_valid, cfg_reset});
        @(posedge mclk) #1 chk("cfg_reset end", 32'h0, cfg_reset);
        host.rd(idx_board_command, v); chk("board_command", command_reset_value, v);
    endtask
    task mid_reset;
        host.wr(idx_board_command, enter_low_power_cmd);
        fill;
        @(posedge mclk) srst <= 1;
        @(posedge mclk) srst <= 0;
        #1 chk("reset pd mv cfg", 32'h1, {power_down, mem_valid, cfg_reset});
        @(posedge mclk) #1 chk("reset cfg end", 32'h0, cfg_reset);
        host.rd(idx_board_command, v); chk("board_command", command_reset_value, v);
    endtask
    task end_of_test;
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 0;
        info;
        power;
        cmd_reset;
        mid_reset;
        end_of_test;
    end
endmodule
